// ---- common/qpwm_pkg.sv ----
package qpwm_pkg;

  // Geometry
  localparam int unsigned CHANNELS = 4;
  localparam int unsigned CNT_W = 24;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned PORT_C_W = 6;
  localparam int unsigned PIN_FIRST = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_LOAD = 4'h0;
  localparam logic [ADDR_W-1:0] REG_CMD = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h8;

  // Reset values
  localparam logic [CNT_W-1:0] LOAD_RESET = 24'h00_0000;
  localparam logic [7:0] CMD_RESET = 8'h00;

  // Command field positions
  localparam int unsigned CMD_QUAL_BIT = 0;
  localparam int unsigned CMD_CHAN_LSB = 1;
  localparam int unsigned CMD_OP_LSB = 4;

  // Opcodes
  localparam logic [3:0] OP_STOP = 4'h0;
  localparam logic [3:0] OP_LOAD = 4'h1;
  localparam logic [3:0] OP_POLARITY = 4'h2;
  localparam logic [3:0] OP_OUT_EN = 4'h3;
  localparam logic [3:0] OP_CLEAR = 4'h4;
  localparam logic [3:0] OP_ROUTE = 4'h5;
  localparam logic [3:0] OP_CLK_SEL = 4'h6;
  localparam logic [3:0] OP_START = 4'h7;

  // Status field positions
  localparam int unsigned ST_RUN_LSB = 0;
  localparam int unsigned ST_OEN_LSB = 4;
  localparam int unsigned ST_POL_LSB = 8;
  localparam int unsigned ST_CLK_LSB = 12;
  localparam int unsigned ST_ROUTE_BIT = 16;
  localparam int unsigned ST_LVL_LSB = 20;
  localparam int unsigned ST_PIN_LSB = 24;

  // Counter clock rates
  localparam int unsigned SYS_CLK_HZ = 200_000_000;
  localparam int unsigned FAST_CLK_HZ = 50_000_000;
  localparam int unsigned SLOW_CLK_HZ = 1_000_000;
  localparam int unsigned FAST_DIV = SYS_CLK_HZ / FAST_CLK_HZ;
  localparam int unsigned SLOW_DIV = SYS_CLK_HZ / SLOW_CLK_HZ;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] opcode;
    logic [2:0] chan;
    logic qual;
  } qpwm_cmd_t;

  typedef struct packed {
    logic start;
    logic stop;
    logic clear;
    logic load;
    logic set_pol;
    logic set_oen;
    logic set_clk;
    logic qual;
  } qpwm_ctl_t;

endpackage : qpwm_pkg

// ---- hdl/qpwm_channel.sv ----
`timescale 1ns/10ps
module qpwm_channel #(
  parameter int unsigned WIDTH = 24
) (
  // Clock, reset and enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Control
  input wire qpwm_pkg::qpwm_ctl_t ctl_i,
  input wire logic [WIDTH-1:0] load_value_i,
  input wire logic fast_tick_i,
  input wire logic slow_tick_i,
  // State
  output logic level_o,
  output logic running_o,
  output logic polarity_o,
  output logic out_en_o,
  output logic clk_sel_o
);

  logic [WIDTH-1:0] period_init_reg, period_init_next;
  logic [WIDTH-1:0] duty_init_reg, duty_init_next;
  logic [WIDTH-1:0] period_counter_reg, period_counter_next;
  logic [WIDTH-1:0] duty_counter_reg, duty_counter_next;
  logic run_reg, run_next;
  logic pol_reg, pol_next;
  logic oen_reg, oen_next;
  logic clk_reg, clk_next;
  logic level_reg, level_next;
  logic tick;
  logic wrap;

  assign tick = run_reg & (clk_reg ? slow_tick_i : fast_tick_i);
  assign wrap = period_counter_reg <= WIDTH'(1);

  always_comb begin
    period_init_next = period_init_reg;
    duty_init_next = duty_init_reg;
    period_counter_next = period_counter_reg;
    duty_counter_next = duty_counter_reg;
    run_next = run_reg;
    pol_next = pol_reg;
    oen_next = oen_reg;
    clk_next = clk_reg;
    if (tick) begin
      if (wrap) begin
        period_counter_next = period_init_reg;
        duty_counter_next = duty_init_reg;
      end else begin
        period_counter_next = period_counter_reg - WIDTH'(1);
        if (duty_counter_reg != '0) begin
          duty_counter_next = duty_counter_reg - WIDTH'(1);
        end
      end
    end
    if (ctl_i.stop) begin
      run_next = 1'b0;
    end
    if (ctl_i.start) begin
      run_next = 1'b1;
      period_counter_next = period_init_reg;
      duty_counter_next = duty_init_reg;
    end
    if (ctl_i.load) begin
      if (ctl_i.qual) begin
        duty_init_next = load_value_i;
      end else begin
        period_init_next = load_value_i;
      end
    end
    if (ctl_i.set_pol) begin
      pol_next = ctl_i.qual;
    end
    if (ctl_i.set_oen) begin
      oen_next = ctl_i.qual;
    end
    if (ctl_i.set_clk) begin
      clk_next = ctl_i.qual;
    end
    if (ctl_i.clear) begin
      period_init_next = '0;
      duty_init_next = '0;
      period_counter_next = '0;
      duty_counter_next = '0;
      run_next = 1'b0;
      pol_next = 1'b0;
      oen_next = 1'b0;
      clk_next = 1'b0;
    end
    // Active at period start while duty remains; inactive is opposite polarity
    level_next = (run_next & oen_next & (duty_counter_next != '0)) ? pol_next : ~pol_next;
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      period_init_reg <= '0;
      duty_init_reg <= '0;
      period_counter_reg <= '0;
      duty_counter_reg <= '0;
      run_reg <= 1'b0;
      pol_reg <= 1'b0;
      oen_reg <= 1'b0;
      clk_reg <= 1'b0;
      level_reg <= 1'b1;
    end else if (ce_i) begin
      period_init_reg <= period_init_next;
      duty_init_reg <= duty_init_next;
      period_counter_reg <= period_counter_next;
      duty_counter_reg <= duty_counter_next;
      run_reg <= run_next;
      pol_reg <= pol_next;
      oen_reg <= oen_next;
      clk_reg <= clk_next;
      level_reg <= level_next;
    end
  end

  assign level_o = level_reg;
  assign running_o = run_reg;
  assign polarity_o = pol_reg;
  assign out_en_o = oen_reg;
  assign clk_sel_o = clk_reg;

endmodule : qpwm_channel

// ---- hdl/qpwm_top.sv ----
`timescale 1ns/10ps
module qpwm_top #(
  parameter int unsigned CHANNELS = qpwm_pkg::CHANNELS,
  parameter int unsigned CNT_W = qpwm_pkg::CNT_W,
  parameter int unsigned FAST_DIV = qpwm_pkg::FAST_DIV,
  parameter int unsigned SLOW_DIV = qpwm_pkg::SLOW_DIV
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // AXI4-Lite write address
  input wire logic [qpwm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // AXI4-Lite read address
  input wire logic [qpwm_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Digital I/O port C settings
  input wire logic [qpwm_pkg::PORT_C_W-1:0] pin_direction_bit_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] dio_out_value_i,
  // Converter clock/trigger claims
  input wire logic [qpwm_pkg::PORT_C_W-1:0] conv_req_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] conv_out_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] conv_oe_i,
  // Port C pins
  input wire logic [qpwm_pkg::PORT_C_W-1:0] port_c_pin_i,
  output logic [qpwm_pkg::PORT_C_W-1:0] port_c_pin_o,
  output logic [qpwm_pkg::PORT_C_W-1:0] port_c_pin_oe_o,
  // Channel levels
  output logic [CHANNELS-1:0] pwm_level_o
);

  localparam int unsigned FAST_W = $clog2(FAST_DIV + 1);
  localparam int unsigned SLOW_W = $clog2(SLOW_DIV + 1);
  localparam int unsigned AW = qpwm_pkg::ADDR_W;
  localparam int unsigned PW = qpwm_pkg::PORT_C_W;

  function automatic logic addr_is(input logic [AW-1:0] addr, input logic [AW-1:0] off);
    addr_is = addr[AW-1:2] == off[AW-1:2];
  endfunction : addr_is

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_word,
                                              input logic [31:0] new_word,
                                              input logic [3:0] strb);
    logic [31:0] res;
    res = old_word;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_word[8*b +: 8];
      end
    end
    merge_bytes = res;
  endfunction : merge_bytes

  // Write channel state
  logic aw_hold_reg;
  logic [AW-1:0] awaddr_reg;
  logic w_hold_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;

  // Read channel state
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;

  // Programming registers
  logic [CNT_W-1:0] load_value_reg;
  qpwm_pkg::qpwm_cmd_t cmd_reg;
  logic cmd_pulse_reg;
  logic route_reg;

  // Prescalers
  logic [FAST_W-1:0] fast_cnt_reg;
  logic [SLOW_W-1:0] slow_cnt_reg;
  logic fast_tick;
  logic slow_tick;

  // Pins
  logic [PW-1:0] pin_out_reg;
  logic [PW-1:0] pin_oe_reg;

  // Write decode
  logic aw_take;
  logic w_take;
  logic have_aw;
  logic have_w;
  logic wr_do;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_load;
  logic wr_cmd;
  logic wr_status;
  logic wr_mapped;
  logic [31:0] load_merged;

  assign s_axi_awready_o = ce_i & ~aw_hold_reg & ~bvalid_reg;
  assign s_axi_wready_o = ce_i & ~w_hold_reg & ~bvalid_reg;
  assign aw_take = s_axi_awvalid_i & s_axi_awready_o;
  assign w_take = s_axi_wvalid_i & s_axi_wready_o;
  assign have_aw = aw_hold_reg | aw_take;
  assign have_w = w_hold_reg | w_take;
  assign wr_do = ce_i & have_aw & have_w & ~bvalid_reg;
  assign wr_addr = aw_hold_reg ? awaddr_reg : s_axi_awaddr_i;
  assign wr_data = w_hold_reg ? wdata_reg : s_axi_wdata_i;
  assign wr_strb = w_hold_reg ? wstrb_reg : s_axi_wstrb_i;
  assign wr_load = wr_do & addr_is(wr_addr, qpwm_pkg::REG_LOAD);
  assign wr_cmd = wr_do & addr_is(wr_addr, qpwm_pkg::REG_CMD) & wr_strb[0];
  assign wr_status = addr_is(wr_addr, qpwm_pkg::REG_STATUS);
  assign wr_mapped = addr_is(wr_addr, qpwm_pkg::REG_LOAD) | addr_is(wr_addr, qpwm_pkg::REG_CMD) | wr_status;
  assign load_merged = merge_bytes({8'h00, load_value_reg}, wr_data, wr_strb);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      aw_hold_reg <= 1'b0;
      awaddr_reg <= '0;
      w_hold_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= qpwm_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (aw_take) begin
        awaddr_reg <= s_axi_awaddr_i;
      end
      if (w_take) begin
        wdata_reg <= s_axi_wdata_i;
        wstrb_reg <= s_axi_wstrb_i;
      end
      aw_hold_reg <= have_aw & ~wr_do;
      w_hold_reg <= have_w & ~wr_do;
      if (wr_do) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? qpwm_pkg::RESP_OKAY : qpwm_pkg::RESP_SLVERR;
      end else if (s_axi_bready_i) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_bvalid_o = bvalid_reg;
  assign s_axi_bresp_o = bresp_reg;

  // Programming registers; a command is held one cycle, then executed
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      load_value_reg <= qpwm_pkg::LOAD_RESET;
      cmd_reg <= qpwm_pkg::CMD_RESET;
      cmd_pulse_reg <= 1'b0;
    end else if (ce_i) begin
      if (wr_load) begin
        load_value_reg <= load_merged[CNT_W-1:0];
      end
      if (wr_cmd) begin
        cmd_reg <= wr_data[7:0];
      end
      cmd_pulse_reg <= wr_cmd;
    end
  end

  // Command decode
  logic op_stop;
  logic op_load;
  logic op_pol;
  logic op_oen;
  logic op_clear;
  logic op_route;
  logic op_clk;
  logic op_start;
  logic scope_all;

  assign op_stop = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_STOP);
  assign op_load = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_LOAD);
  assign op_pol = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_POLARITY);
  assign op_oen = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_OUT_EN);
  assign op_clear = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_CLEAR);
  assign op_route = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_ROUTE);
  assign op_clk = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_CLK_SEL);
  assign op_start = cmd_pulse_reg & (cmd_reg.opcode == qpwm_pkg::OP_START);
  assign scope_all = cmd_reg.qual;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      route_reg <= 1'b0;
    end else if (ce_i && op_route) begin
      route_reg <= cmd_reg.qual;
    end
  end

  // Internal clock enables for the counters
  assign fast_tick = fast_cnt_reg == FAST_W'(FAST_DIV - 1);
  assign slow_tick = slow_cnt_reg == SLOW_W'(SLOW_DIV - 1);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      fast_cnt_reg <= '0;
      slow_cnt_reg <= '0;
    end else if (ce_i) begin
      fast_cnt_reg <= fast_tick ? '0 : fast_cnt_reg + FAST_W'(1);
      slow_cnt_reg <= slow_tick ? '0 : slow_cnt_reg + SLOW_W'(1);
    end
  end

  // Channels
  logic [CHANNELS-1:0] ch_level;
  logic [CHANNELS-1:0] ch_run;
  logic [CHANNELS-1:0] ch_pol;
  logic [CHANNELS-1:0] ch_oen;
  logic [CHANNELS-1:0] ch_clk;

  for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
    logic hit;
    qpwm_pkg::qpwm_ctl_t ctl;

    assign hit = {1'b0, cmd_reg.chan} == 4'(i);
    assign ctl.stop = op_stop & (hit | scope_all);
    assign ctl.start = op_start & (hit | scope_all);
    assign ctl.clear = op_clear & (hit | scope_all);
    assign ctl.load = op_load & hit;
    assign ctl.set_pol = op_pol & hit;
    assign ctl.set_oen = op_oen & hit;
    assign ctl.set_clk = op_clk & hit;
    assign ctl.qual = cmd_reg.qual;

    qpwm_channel #(
      .WIDTH(CNT_W)
    ) u_channel (
      .sys_clk_i(sys_clk_i),
      .rst_n_i(rst_n_i),
      .ce_i(ce_i),
      .ctl_i(ctl),
      .load_value_i(load_value_reg),
      .fast_tick_i(fast_tick),
      .slow_tick_i(slow_tick),
      .level_o(ch_level[i]),
      .running_o(ch_run[i]),
      .polarity_o(ch_pol[i]),
      .out_en_o(ch_oen[i]),
      .clk_sel_o(ch_clk[i])
    );
  end

  assign pwm_level_o = ch_level;

  // Port C pin muxing
  logic [PW-1:0] pwm_claim;
  logic [PW-1:0] pwm_pin_val;
  logic [PW-1:0] pin_out_next;
  logic [PW-1:0] pin_oe_next;

  for (genvar p = 0; p < PW; p++) begin : g_pin
    if (p >= qpwm_pkg::PIN_FIRST && p < qpwm_pkg::PIN_FIRST + CHANNELS) begin : g_pwm
      assign pwm_claim[p] = route_reg;
      assign pwm_pin_val[p] = ch_level[p - qpwm_pkg::PIN_FIRST];
    end else begin : g_none
      assign pwm_claim[p] = 1'b0;
      assign pwm_pin_val[p] = 1'b0;
    end
    assign pin_out_next[p] = conv_req_i[p] ? conv_out_i[p] :
                             pwm_claim[p] ? pwm_pin_val[p] : dio_out_value_i[p];
    assign pin_oe_next[p] = conv_req_i[p] ? conv_oe_i[p] :
                            pwm_claim[p] ? 1'b1 : pin_direction_bit_i[p];
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      pin_out_reg <= '0;
      pin_oe_reg <= '0;
    end else if (ce_i) begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign port_c_pin_o = pin_out_reg;
  assign port_c_pin_oe_o = pin_oe_reg;

  // Read side
  logic ar_take;
  logic [31:0] status_word;
  logic [31:0] rd_word;
  logic rd_mapped;

  assign s_axi_arready_o = ce_i & ~rvalid_reg;
  assign ar_take = s_axi_arvalid_i & s_axi_arready_o;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[qpwm_pkg::ST_RUN_LSB +: CHANNELS] = ch_run;
    status_word[qpwm_pkg::ST_OEN_LSB +: CHANNELS] = ch_oen;
    status_word[qpwm_pkg::ST_POL_LSB +: CHANNELS] = ch_pol;
    status_word[qpwm_pkg::ST_CLK_LSB +: CHANNELS] = ch_clk;
    status_word[qpwm_pkg::ST_ROUTE_BIT] = route_reg;
    status_word[qpwm_pkg::ST_LVL_LSB +: CHANNELS] = ch_level;
    status_word[qpwm_pkg::ST_PIN_LSB +: PW] = port_c_pin_i;
  end

  assign rd_mapped = addr_is(s_axi_araddr_i, qpwm_pkg::REG_LOAD) |
                     addr_is(s_axi_araddr_i, qpwm_pkg::REG_CMD) |
                     addr_is(s_axi_araddr_i, qpwm_pkg::REG_STATUS);
  assign rd_word = addr_is(s_axi_araddr_i, qpwm_pkg::REG_LOAD) ? {8'h00, load_value_reg} :
                   addr_is(s_axi_araddr_i, qpwm_pkg::REG_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
      rresp_reg <= qpwm_pkg::RESP_OKAY;
    end else if (ce_i) begin
      if (ar_take) begin
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_mapped ? qpwm_pkg::RESP_OKAY : qpwm_pkg::RESP_SLVERR;
      end else if (s_axi_rready_i) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  assign s_axi_rvalid_o = rvalid_reg;
  assign s_axi_rdata_o = rdata_reg;
  assign s_axi_rresp_o = rresp_reg;

endmodule : qpwm_top

// ---- testbench/qpwm_tb.sv ----
`timescale 1ns/10ps
module qpwm_top_tb;
  localparam int FDIV = 4;
  localparam int SDIV = 8;
  logic sys_clk_i = 0;
  logic rst_n_i = 0;
  logic ce_i = 1;
  logic [3:0] s_axi_awaddr_i = 0, s_axi_araddr_i = 0, s_axi_wstrb_i = 0;
  logic s_axi_awvalid_i = 0, s_axi_wvalid_i = 0, s_axi_bready_i = 0, s_axi_arvalid_i = 0, s_axi_rready_i = 0;
  logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic [31:0] s_axi_wdata_i = 0, s_axi_rdata_o, d, rv;
  logic [1:0] s_axi_bresp_o, s_axi_rresp_o, r;
  logic [5:0] pin_direction_bit_i = 0, dio_out_value_i = 0, conv_req_i = 0, conv_out_i = 0, conv_oe_i = 0;
  logic [5:0] port_c_pin_i = 0, port_c_pin_o, port_c_pin_oe_o;
  logic [3:0] pwm_level_o, m_run = 0, m_oen = 0, m_pol = 0, m_clk = 0;
  logic m_route = 0;
  int fail_count = 0, cmp_count = 0, seed = 53;

  qpwm_top #(.FAST_DIV(FDIV), .SLOW_DIV(SDIV)) dut (.*);

  always #2.5 sys_clk_i = ~sys_clk_i;

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t %s: seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic stall(input int n);
    if (n >= 40) begin
      chk(0, 1, "bus timeout");
      end_of_test();
    end
  endtask : stall

  // Bus tasks start and end just after a rising edge; readies are sampled mid-cycle
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [3:0] s, output logic [1:0] rs);
    logic ta, tw, tb;
    int n;
    s_axi_awaddr_i <= a;
    s_axi_wdata_i <= v;
    s_axi_wstrb_i <= s;
    s_axi_awvalid_i <= 1;
    s_axi_wvalid_i <= 1;
    s_axi_bready_i <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk_i);
      ta = s_axi_awvalid_i & s_axi_awready_o;
      tw = s_axi_wvalid_i & s_axi_wready_o;
      tb = s_axi_bvalid_o;
      rs = s_axi_bresp_o;
      @(posedge sys_clk_i);
      if (ta) s_axi_awvalid_i <= 0;
      if (tw) s_axi_wvalid_i <= 0;
      if (tb) break;
    end
    s_axi_bready_i <= 0;
    // Let an edge pass so a following call never re-raises ready in this step
    @(posedge sys_clk_i);
    stall(n);
  endtask : axi_wr

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, tb;
    int n;
    s_axi_araddr_i <= a;
    s_axi_arvalid_i <= 1;
    s_axi_rready_i <= 1;
    for (n = 0; n < 40; n++) begin
      @(negedge sys_clk_i);
      ta = s_axi_arvalid_i & s_axi_arready_o;
      tb = s_axi_rvalid_o;
      v = s_axi_rdata_o;
      rs = s_axi_rresp_o;
      @(posedge sys_clk_i);
      if (ta) s_axi_arvalid_i <= 0;
      if (tb) break;
    end
    s_axi_rready_i <= 0;
    @(posedge sys_clk_i);
    stall(n);
  endtask : axi_rd

  function automatic logic [3:0] upd(input logic [3:0] v, input logic [3:0] m, input logic q);
    return q ? (v | m) : (v & ~m);
  endfunction : upd

  function automatic logic [31:0] exp_st();
    return {2'b00, port_c_pin_i, 7'h00, m_route, m_clk, m_pol, m_oen, m_run};
  endfunction : exp_st

  // Issue one command, advance the model, compare the status word
  task automatic cmd(input logic [3:0] op, input logic [2:0] ch, input logic q);
    qpwm_pkg::qpwm_cmd_t c;
    logic [3:0] one, sel;
    logic [31:0] st;
    c = '{op, ch, q};
    one = 4'h1 << ch;
    sel = q ? 4'hF : one;
    axi_wr(qpwm_pkg::REG_CMD, {24'h00_0000, c}, 4'h1, r);
    case (op)
      qpwm_pkg::OP_STOP: m_run = upd(m_run, sel, 0);
      qpwm_pkg::OP_START: m_run = upd(m_run, sel, 1);
      qpwm_pkg::OP_POLARITY: m_pol = upd(m_pol, one, q);
      qpwm_pkg::OP_OUT_EN: m_oen = upd(m_oen, one, q);
      qpwm_pkg::OP_CLK_SEL: m_clk = upd(m_clk, one, q);
      qpwm_pkg::OP_ROUTE: m_route = q;
      qpwm_pkg::OP_CLEAR: begin
        m_run = upd(m_run, sel, 0);
        m_oen = upd(m_oen, sel, 0);
        m_pol = upd(m_pol, sel, 0);
        m_clk = upd(m_clk, sel, 0);
      end
      default: ;
    endcase
    axi_rd(qpwm_pkg::REG_STATUS, st, r);
    chk(st & 32'hFF0F_FFFF, exp_st(), "status");
  endtask : cmd

  task automatic ld(input logic q, input logic [31:0] v);
    axi_wr(qpwm_pkg::REG_LOAD, v, 4'hF, r);
    cmd(qpwm_pkg::OP_LOAD, 3'h0, q);
  endtask : ld

  // Skips the first, phase-dependent period and times a whole later one
  task automatic meas(input int div, input int p, input int dt);
    int hi, tot, rises, n;
    logic prev;
    ld(0, p);
    ld(1, dt);
    cmd(qpwm_pkg::OP_START, 3'h0, 0);
    hi = 0;
    tot = 0;
    rises = 0;
    prev = 1;
    for (n = 0; n < 3000 && rises < 3; n++) begin
      @(negedge sys_clk_i);
      rises += int'(pwm_level_o[0] && !prev);
      if (rises == 2) begin
        tot++;
        hi += int'(pwm_level_o[0]);
      end
      prev = pwm_level_o[0];
    end
    if (rises < 3) begin
      stall(40);
    end
    @(posedge sys_clk_i);
    chk(hi, dt * div, "active length");
    chk(tot, p * div, "period length");
  endtask : meas

  task automatic steady(input logic e);
    int bad;
    bad = 0;
    repeat (8) @(posedge sys_clk_i);
    repeat (60) begin
      @(negedge sys_clk_i);
      bad += int'({port_c_pin_o[2], pwm_level_o[0]} !== {2{e}});
    end
    @(posedge sys_clk_i);
    chk(bad, 0, "steady level");
  endtask : steady

  initial begin
    repeat (4) @(posedge sys_clk_i);
    rst_n_i <= 1;
    @(posedge sys_clk_i);
    axi_rd(qpwm_pkg::REG_LOAD, d, r);
    chk(d, 0, "load reset");
    axi_rd(qpwm_pkg::REG_STATUS, d, r);
    chk(d & 32'hFF0F_FFFF, exp_st(), "status reset");
    axi_wr(qpwm_pkg::REG_LOAD, 32'hFFFF_FFFF, 4'hF, r);
    axi_rd(qpwm_pkg::REG_LOAD, d, r);
    chk(d, 32'h00FF_FFFF, "load width");
    axi_rd(4'hC, d, r);
    chk(r, qpwm_pkg::RESP_SLVERR, "unmapped read");
    axi_wr(4'hC, 32'h0000_0071, 4'hF, r);
    chk(r, qpwm_pkg::RESP_SLVERR, "unmapped write");
    axi_rd(qpwm_pkg::REG_CMD, d, r);
    chk(d, 0, "command read");
    $display("test registers done");
    for (int k = 0; k < 40; k++) begin
      rv = $random(seed);
      {conv_oe_i, conv_out_i, conv_req_i, dio_out_value_i, pin_direction_bit_i} <= rv[29:0];
      port_c_pin_i <= rv[31:26];
      cmd(rv[3:0], rv[6:4], rv[7]);
    end
    $display("test random commands done");
    conv_req_i <= 0;
    pin_direction_bit_i <= 0;
    cmd(qpwm_pkg::OP_CLEAR, 3'h0, 1);
    cmd(qpwm_pkg::OP_POLARITY, 3'h0, 1);
    cmd(qpwm_pkg::OP_OUT_EN, 3'h0, 1);
    cmd(qpwm_pkg::OP_ROUTE, 3'h0, 1);
    for (int k = 0; k < 2; k++) begin
      cmd(qpwm_pkg::OP_CLK_SEL, 3'h0, k[0]);
      meas(k ? SDIV : FDIV, 5, 2);
    end
    chk(port_c_pin_oe_o[5:2], 4'hF, "routed pins driven");
    ld(1, 5);
    cmd(qpwm_pkg::OP_START, 3'h0, 0);
    steady(1);
    ld(1, 0);
    cmd(qpwm_pkg::OP_START, 3'h0, 0);
    steady(0);
    ld(1, 5);
    cmd(qpwm_pkg::OP_START, 3'h0, 0);
    cmd(qpwm_pkg::OP_OUT_EN, 3'h0, 0);
    steady(0);
    cmd(qpwm_pkg::OP_POLARITY, 3'h0, 0);
    steady(1);
    // Freeze a pulsing channel so the enable has something to hold
    ld(1, 2);
    cmd(qpwm_pkg::OP_OUT_EN, 3'h0, 1);
    ce_i <= 0;
    @(negedge sys_clk_i);
    d = pwm_level_o;
    repeat (10) @(posedge sys_clk_i);
    chk(pwm_level_o, d, "frozen level");
    ce_i <= 1;
    $display("test pulse output done");
    cmd(qpwm_pkg::OP_ROUTE, 3'h0, 0);
    pin_direction_bit_i <= 6'h2A;
    dio_out_value_i <= 6'h3C;
    repeat (4) @(posedge sys_clk_i);
    chk(port_c_pin_oe_o, 6'h2A, "unrouted direction");
    chk(port_c_pin_o & 6'h2A, 6'h28, "unrouted value");
    $display("test pin routing done");
    end_of_test();
  end
endmodule : qpwm_top_tb

// ---- testbench/qpwm_top_props.sv ----
`timescale 1ns/10ps
module qpwm_props #(
  parameter int unsigned CHANNELS = 4
) (
  // Clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Register bus
  input wire logic [qpwm_pkg::ADDR_W-1:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  input wire logic s_axi_awready_o,
  input wire logic s_axi_wvalid_i,
  input wire logic s_axi_wready_o,
  input wire logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [qpwm_pkg::ADDR_W-1:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  input wire logic s_axi_arready_o,
  input wire logic [1:0] s_axi_rresp_o,
  input wire logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // Port C
  input wire logic [qpwm_pkg::PORT_C_W-1:0] pin_direction_bit_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] dio_out_value_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] conv_req_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] conv_oe_i,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] port_c_pin_o,
  input wire logic [qpwm_pkg::PORT_C_W-1:0] port_c_pin_oe_o,
  input wire logic [CHANNELS-1:0] pwm_level_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_RST_VALUES: assert property ($rose(rst_n_i) |-> pwm_level_o == '1 && port_c_pin_oe_o == '0
    && !s_axi_bvalid_o && !s_axi_rvalid_o) else $error("state after reset not cleared");
  AST_WRITE_RESP: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
    |=> s_axi_bvalid_o && s_axi_bresp_o == ($past(s_axi_awaddr_i) == 4'hC ? 2'h2 : 2'h0))
    else $error("write response missing or wrong");
  AST_B_BLOCKS: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write accepted while response pending");
  AST_B_ONCE: assert property (ce_i && s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
    else $error("write response repeated");
  AST_READ_RESP: assert property (s_axi_arvalid_i && s_axi_arready_o
    |=> s_axi_rvalid_o && s_axi_rresp_o == ($past(s_axi_araddr_i) == 4'hC ? 2'h2 : 2'h0))
    else $error("read response missing or wrong");
  AST_R_ONCE: assert property (ce_i && s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
    else $error("read response repeated");
  AST_CONV_WINS: assert property (ce_i && conv_req_i[2] |=> port_c_pin_oe_o[2] == $past(conv_oe_i[2]))
    else $error("converter claim lost on shared pin");
  AST_DIO_PLAIN: assert property (ce_i && !conv_req_i[0] |=> port_c_pin_oe_o[0] == $past(pin_direction_bit_i[0])
    && (!$past(pin_direction_bit_i[0]) || port_c_pin_o[0] == $past(dio_out_value_i[0])))
    else $error("plain pin not following direction and value");
  AST_CE_FREEZE: assert property (!ce_i |=> $stable(pwm_level_o) && $stable(port_c_pin_oe_o))
    else $error("state moved while clock enable low");
endmodule : qpwm_props

bind qpwm_top qpwm_props #(.CHANNELS(CHANNELS)) u_props (.*);
